// ---- idmd_chk_sva.sv ----
// Assertions for the internal data memory decoder
`timescale 1ns/1ps
`default_nettype none
module idmd_chk (
  input wire logic core_clk, // Clock
  input wire logic reset, // Reset
  input wire logic req_valid, // Request
  input wire logic req_ready_ff, // Ready
  input wire logic req_indirect, // Mode
  input wire logic req_bit, // Bit access
  input wire logic req_ext, // Extra RAM
  input wire logic [9:0] req_addr, // Address
  input wire logic ack_ff, // Done
  input wire logic hit_bank_ff, // Bank flag
  input wire logic [1:0] bank_num_ff, // Bank
  input wire logic hit_bitarea_ff, // Bit area flag
  input wire logic sfs_valid_ff, // Strobe
  input wire logic [7:0] sfs_addr_ff, // Address out
  input wire logic sfs_bit_en_ff, // Bit enable
  input wire logic [2:0] sfs_bit_sel_ff // Bit select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Taken request to the 256-byte space and its upper-half flag
  wire tk = req_valid && req_ready_ff && !req_ext;
  wire up = req_addr[7];
  a_upper_dual_map: assert property (tk && !req_bit && up |=>
    sfs_valid_ff == !$past(req_indirect)) else $error("upper half mapped wrongly");
  a_indirect_upper_ram: assert property (tk && !req_bit && up && req_indirect |->
    ##2 ack_ff) else $error("indirect upper read late");
  a_direct_sfs_addr: assert property (tk && !req_bit && up && !req_indirect |=>
    sfs_addr_ff == $past(req_addr[7:0]) ##2 ack_ff) else $error("direct upper not sent out");
  a_lower_same_ram: assert property (tk && !req_bit && !up |=>
    !sfs_valid_ff ##1 ack_ff) else $error("lower byte left the RAM");
  a_bank_flag_num: assert property (tk && !req_bit && req_addr[7:5] == 3'h0 |=>
    hit_bank_ff && bank_num_ff == $past(req_addr[4:3])) else $error("bank flag wrong");
  a_bitarea_flag: assert property (tk && (req_bit ? !up : req_addr[7:4] == 4'h2) |=>
    hit_bitarea_ff) else $error("bit area flag missing");
  a_ext_ram_ack: assert property (req_valid && req_ready_ff && req_ext |=>
    !sfs_valid_ff ##1 ack_ff) else $error("extra RAM access wrong");
  a_sfs_bit_sel: assert property (tk && req_bit && up |=> sfs_bit_en_ff &&
    sfs_bit_sel_ff == $past(req_addr[2:0]) && sfs_addr_ff == {$past(req_addr[7:3]), 3'h0})
    else $error("bit select wrong");
  c_sfs: cover property (sfs_valid_ff);
  c_bank: cover property (ack_ff && hit_bank_ff);
  c_bit: cover property (ack_ff && hit_bitarea_ff);
endmodule : idmd_chk
bind idmd_decoder idmd_chk i_chk (
  .core_clk(core_clk),
  .reset(reset),
  .req_valid(req_valid),
  .req_ready_ff(req_ready_ff),
  .req_indirect(req_indirect),
  .req_bit(req_bit),
  .req_ext(req_ext),
  .req_addr(req_addr),
  .ack_ff(ack_ff),
  .hit_bank_ff(hit_bank_ff),
  .bank_num_ff(bank_num_ff),
  .hit_bitarea_ff(hit_bitarea_ff),
  .sfs_valid_ff(sfs_valid_ff),
  .sfs_addr_ff(sfs_addr_ff),
  .sfs_bit_en_ff(sfs_bit_en_ff),
  .sfs_bit_sel_ff(sfs_bit_sel_ff)
);
`default_nettype wire

// ---- idmd_decoder.sv ----
// Internal data memory decoder: steers core data accesses to RAM or the special function space
`timescale 1ns/1ps
`default_nettype none

// Function
// - 256 directly reachable bytes; upper 128 dual-mapped by addressing mode
// - Indirect access to upper half selects upper 128 bytes of general RAM
// - Direct access to upper half selects the special function space
// - Lower 128 bytes reach the same RAM in direct and indirect modes
// - First 32 bytes form four eight-byte working register banks
// - The 16 bytes after the banks allow byte and bit access
// - Further 512 bytes of internal RAM, 768 bytes in total
module idmd_decoder
  import idmd_pkg::*;
#(
  parameter int unsigned EXT_BYTES = IDMD_EXT_BYTES
) (
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic req_valid, // Core access request
  input wire logic req_write, // Write when high, read when low
  input wire logic req_indirect, // Indirect addressing when high
  input wire logic req_bit, // Bit access, req_addr holds a bit address
  input wire logic req_ext, // Access to the extra RAM block
  input wire logic [9:0] req_addr, // Byte, bit or extra RAM address
  input wire logic [7:0] req_wdata, // Write data, bit value in bit 0
  output logic req_ready_ff, // Decoder can take a request
  output logic ack_ff, // Access done, one-cycle pulse
  output logic [7:0] ack_rdata_ff, // Read data, bit reads in bit 0
  output logic hit_bank_ff, // Last access was a byte access within a register bank
  output logic [1:0] bank_num_ff, // Bank number of that access
  output logic hit_bitarea_ff, // Last access used the bit-addressable bytes
  output logic sfs_valid_ff, // Special function space strobe, one cycle
  output logic sfs_write_ff, // Special function space write
  output logic [7:0] sfs_addr_ff, // Special function space byte address
  output logic sfs_bit_en_ff, // Access targets one bit of the byte
  output logic [2:0] sfs_bit_sel_ff, // Bit within the byte
  output logic [7:0] sfs_wdata_ff, // Write data to the special function space
  input wire logic [7:0] sfs_rdata // Read data, valid the cycle after the strobe
);

  // Extra RAM must fit beside the direct space within the physical depth
  if (EXT_BYTES == 0 || EXT_BYTES + IDMD_DIRECT_BYTES > (1 << IDMD_PHYS_W)) begin : g_chk
    $error("idmd_decoder: EXT_BYTES out of range");
  end

  localparam int unsigned DEPTH = IDMD_DIRECT_BYTES + EXT_BYTES;

  // Pick the target of a byte address by addressing mode
  function automatic idmd_target_type target_of(input logic [7:0] a, input logic ind);
    if (a < IDMD_UPPER_BASE) begin
      target_of = idmd_tgt_lower;
    end else if (ind) begin
      target_of = idmd_tgt_upper;
    end else begin
      target_of = idmd_tgt_sfs;
    end
  endfunction : target_of

  // Byte that holds a bit address
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    if (b[7]) begin
      bit_byte = {b[7:3], 3'b000};
    end else begin
      bit_byte = IDMD_BITAREA_BASE + {4'h0, b[6:3]};
    end
  endfunction : bit_byte

  // Physical RAM word of a direct-space or extra-space address
  function automatic logic [IDMD_PHYS_W-1:0] phys_of(input logic ext, input logic [9:0] a);
    if (ext) begin
      phys_of = IDMD_PHYS_W'(IDMD_DIRECT_BYTES) + a;
    end else begin
      phys_of = {2'b00, a[7:0]};
    end
  endfunction : phys_of

  idmd_state_type state_ff;
  idmd_state_type nxt_state;
  idmd_target_type cur_tgt;
  logic [7:0] byte_addr;
  logic [IDMD_PHYS_W-1:0] cur_phys;
  logic take;
  logic ext_ok;
  logic [IDMD_PHYS_W-1:0] phys_ff;
  logic bit_ff;
  logic write_ff;
  logic [2:0] bit_sel_ff;
  logic bit_val_ff;
  logic mem_en;
  logic mem_we;
  logic [IDMD_PHYS_W-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  // Decode the incoming request
  assign take = req_valid && req_ready_ff;
  assign byte_addr = req_bit ? bit_byte(req_addr[7:0]) : req_addr[7:0];
  assign ext_ok = req_addr < 10'(EXT_BYTES);
  always_comb begin
    if (req_ext) begin
      cur_tgt = idmd_tgt_ext;
    end else if (req_bit) begin
      cur_tgt = req_addr[7] ? idmd_tgt_sfs : idmd_tgt_lower;
    end else begin
      cur_tgt = target_of(byte_addr, req_indirect);
    end
  end
  assign cur_phys = phys_of(req_ext, {req_addr[9:8], byte_addr});

  // Sequencer: RAM accesses finish in two cycles, special function ones in three
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      idmd_idle: begin
        if (take) begin
          if (cur_tgt == idmd_tgt_sfs) begin
            nxt_state = idmd_sfs_wait;
          end else begin
            nxt_state = idmd_mem_data;
          end
        end
      end
      idmd_mem_data: begin
        nxt_state = idmd_idle;
      end
      idmd_sfs_wait: begin
        nxt_state = idmd_sfs_data;
      end
      idmd_sfs_data: begin
        nxt_state = idmd_idle;
      end
      default: begin
        nxt_state = idmd_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= idmd_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ready only while idle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= (nxt_state == idmd_idle);
    end
  end

  // Hold the request while it is served
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phys_ff <= '0;
      bit_ff <= 1'b0;
      write_ff <= 1'b0;
      bit_sel_ff <= 3'h0;
      bit_val_ff <= 1'b0;
    end else if (take) begin
      phys_ff <= cur_phys;
      bit_ff <= req_bit;
      write_ff <= req_write;
      bit_sel_ff <= req_addr[2:0];
      bit_val_ff <= req_wdata[0];
    end
  end

  // RAM port: request cycle reads or writes a byte, bit writes merge one cycle later
  always_comb begin
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = cur_phys;
    mem_wdata = req_wdata;
    if (state_ff == idmd_idle && take && cur_tgt != idmd_tgt_sfs) begin
      mem_en = !req_ext || ext_ok;
      mem_we = req_write && !req_bit;
    end else if (state_ff == idmd_mem_data && bit_ff && write_ff) begin
      mem_en = 1'b1;
      mem_we = 1'b1;
      mem_addr = phys_ff;
      mem_wdata = mem_rdata;
      mem_wdata[bit_sel_ff] = bit_val_ff;
    end
  end

  idmd_ram #(
    .DEPTH(DEPTH),
    .AW(IDMD_PHYS_W),
    .DW(IDMD_DATA_W)
  ) u_ram (
    .core_clk(core_clk),
    .en(mem_en),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_ff(mem_rdata)
  );

  // Region flags for the accepted access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hit_bank_ff <= 1'b0;
      bank_num_ff <= 2'h0;
      hit_bitarea_ff <= 1'b0;
    end else if (take) begin
      hit_bank_ff <= !req_ext && !req_bit && byte_addr <= IDMD_BANK_END;
      bank_num_ff <= byte_addr[IDMD_BANK_SEL_LSB+1:IDMD_BANK_SEL_LSB];
      hit_bitarea_ff <= !req_ext && (cur_tgt == idmd_tgt_lower)
          && byte_addr >= IDMD_BITAREA_BASE && byte_addr <= IDMD_BITAREA_END;
    end
  end

  // Special function space strobe and fields
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfs_valid_ff <= 1'b0;
      sfs_write_ff <= 1'b0;
      sfs_addr_ff <= IDMD_UPPER_BASE;
      sfs_bit_en_ff <= 1'b0;
      sfs_bit_sel_ff <= 3'h0;
      sfs_wdata_ff <= IDMD_RDATA_RST;
    end else begin
      sfs_valid_ff <= take && cur_tgt == idmd_tgt_sfs;
      if (take && cur_tgt == idmd_tgt_sfs) begin
        sfs_write_ff <= req_write;
        sfs_addr_ff <= byte_addr;
        sfs_bit_en_ff <= req_bit;
        sfs_bit_sel_ff <= req_addr[2:0];
        sfs_wdata_ff <= req_wdata;
      end
    end
  end

  // Answer to the core
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      ack_rdata_ff <= IDMD_RDATA_RST;
    end else begin
      ack_ff <= (state_ff == idmd_mem_data) || (state_ff == idmd_sfs_data);
      if (state_ff == idmd_mem_data && !write_ff) begin
        ack_rdata_ff <= bit_ff ? {7'h00, mem_rdata[bit_sel_ff]} : mem_rdata;
      end else if (state_ff == idmd_sfs_data && !write_ff) begin
        ack_rdata_ff <= bit_ff ? {7'h00, sfs_rdata[bit_sel_ff]} : sfs_rdata;
      end
    end
  end

endmodule : idmd_decoder

`default_nettype wire

// ---- idmd_pkg.sv ----
// Constants shared by the internal data memory decoder files
`default_nettype none

package idmd_pkg;

  // Address space sizes in bytes
  localparam int unsigned IDMD_DIRECT_BYTES = 256;
  localparam int unsigned IDMD_LOWER_BYTES = 128;
  localparam int unsigned IDMD_EXT_BYTES = 512;
  localparam int unsigned IDMD_TOTAL_BYTES = 768;

  // Widths of the access ports
  localparam int unsigned IDMD_DATA_W = 8;
  localparam int unsigned IDMD_PHYS_W = 10;

  // Working register banks at the bottom of the lower RAM
  localparam logic [7:0] IDMD_BANK_BASE = 8'h00;
  localparam logic [7:0] IDMD_BANK_END = 8'h1f;
  localparam int unsigned IDMD_BANK_SEL_LSB = 3;

  // Bit-addressable bytes that follow the banks
  localparam logic [7:0] IDMD_BITAREA_BASE = 8'h20;
  localparam logic [7:0] IDMD_BITAREA_END = 8'h2f;
  localparam int unsigned IDMD_BIT_SEL_W = 3;

  // First address of the dual-mapped upper half
  localparam logic [7:0] IDMD_UPPER_BASE = 8'h80;

  // Reset values of the answer path
  localparam logic [7:0] IDMD_RDATA_RST = 8'h00;

  // Targets of a decoded access
  typedef enum logic [1:0] {
    idmd_tgt_lower,
    idmd_tgt_upper,
    idmd_tgt_sfs,
    idmd_tgt_ext
  } idmd_target_type;

  // Sequencer states
  typedef enum logic [1:0] {
    idmd_idle,
    idmd_mem_data,
    idmd_sfs_wait,
    idmd_sfs_data
  } idmd_state_type;

endpackage : idmd_pkg

`default_nettype wire

// ---- idmd_ram.sv ----
// Single-port data RAM with registered read data
`timescale 1ns/1ps
`default_nettype none

module idmd_ram #(
  parameter int unsigned DEPTH = 768,
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 8
) (
  input wire logic core_clk, // System clock
  input wire logic en, // Access strobe
  input wire logic we, // Write when high
  input wire logic [AW-1:0] addr, // Word address
  input wire logic [DW-1:0] wdata, // Write data
  output logic [DW-1:0] rdata_ff // Registered read data
);

  logic [DW-1:0] mem [DEPTH];

  // Depth must fit the address width
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("idmd_ram: DEPTH does not fit AW");
  end

  // Write, or read into the output register
  always_ff @(posedge core_clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end else begin
        rdata_ff <= mem[addr];
      end
    end
  end

endmodule : idmd_ram

`default_nettype wire

// ---- idmd_sfs_model.sv ----
// Special function space model answering the decoder strobe
`timescale 1ns/1ps
`default_nettype none
module idmd_sfs_model (
  input wire logic core_clk, // Clock
  input wire logic sfs_valid_ff, // Strobe
  input wire logic sfs_write_ff, // Write
  input wire logic [7:0] sfs_addr_ff, // Address
  input wire logic [7:0] sfs_wdata_ff, // Write data
  input wire logic sfs_bit_en_ff, // Bit access
  input wire logic [2:0] sfs_bit_sel_ff, // Bit within the byte
  output logic [7:0] sfs_rdata // Read data
);
  logic [7:0] mem [128];
  initial sfs_rdata = 8'h00;
  // Data valid only the cycle after a read strobe, toggling otherwise
  always @(posedge core_clk) begin
    if (sfs_valid_ff && sfs_write_ff) begin
      if (sfs_bit_en_ff) begin
        mem[sfs_addr_ff[6:0]][sfs_bit_sel_ff] <= sfs_wdata_ff[0]; // Peripheral merges the bit
      end else begin
        mem[sfs_addr_ff[6:0]] <= sfs_wdata_ff;
      end
    end
    if (sfs_valid_ff && !sfs_write_ff) begin
      sfs_rdata <= mem[sfs_addr_ff[6:0]];
    end else begin
      sfs_rdata <= ~sfs_rdata;
    end
  end
endmodule : idmd_sfs_model
`default_nettype wire

// ---- internal_data_memory_decoder_tb.sv ----
// Self-checking bench for the internal data memory decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module internal_data_memory_decoder_tb;
  import idmd_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_indirect = 1'b0, req_bit = 1'b0, req_ext = 1'b0;
  logic [9:0] req_addr = 10'h000;
  logic [7:0] req_wdata = 8'h00, sfs_rdata, rd, ack_rdata_ff, sfs_addr_ff, sfs_wdata_ff;
  logic req_ready_ff, ack_ff, hit_bank_ff, hit_bitarea_ff;
  logic sfs_valid_ff, sfs_write_ff, sfs_bit_en_ff;
  logic [1:0] bank_num_ff;
  logic [2:0] sfs_bit_sel_ff;
  int fails = 0, checked = 0, cycles = 0;
  always #12.5 core_clk = ~core_clk;
  idmd_decoder i_dut (
    .core_clk(core_clk),
    .reset(reset),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_indirect(req_indirect),
    .req_bit(req_bit),
    .req_ext(req_ext),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_ready_ff(req_ready_ff),
    .ack_ff(ack_ff),
    .ack_rdata_ff(ack_rdata_ff),
    .hit_bank_ff(hit_bank_ff),
    .bank_num_ff(bank_num_ff),
    .hit_bitarea_ff(hit_bitarea_ff),
    .sfs_valid_ff(sfs_valid_ff),
    .sfs_write_ff(sfs_write_ff),
    .sfs_addr_ff(sfs_addr_ff),
    .sfs_bit_en_ff(sfs_bit_en_ff),
    .sfs_bit_sel_ff(sfs_bit_sel_ff),
    .sfs_wdata_ff(sfs_wdata_ff),
    .sfs_rdata(sfs_rdata)
  );
  idmd_sfs_model i_sfs (
    .core_clk(core_clk),
    .sfs_valid_ff(sfs_valid_ff),
    .sfs_write_ff(sfs_write_ff),
    .sfs_addr_ff(sfs_addr_ff),
    .sfs_wdata_ff(sfs_wdata_ff),
    .sfs_bit_en_ff(sfs_bit_en_ff),
    .sfs_bit_sel_ff(sfs_bit_sel_ff),
    .sfs_rdata(sfs_rdata)
  );
  // One access; mode bits are write, indirect, bit, extra
  task automatic acc(input logic [3:0] m, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready_ff !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    {req_write, req_indirect, req_bit, req_ext, req_addr, req_wdata} = {m, a, d};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    `CHK("busy", 1'b0, req_ready_ff)
    while (ack_ff !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("ack", 1'b1, ack_ff)
    rd = ack_rdata_ff;
  endtask : acc
  // Upper half reached two ways
  task automatic t_dual;
    acc(4'h8, 10'h090, 8'h3c);
    acc(4'hc, 10'h090, 8'hc3);
    acc(4'h0, 10'h090, 8'h00);
    `CHK("sfs byte", 8'h3c, rd)
    acc(4'h4, 10'h090, 8'h00);
    `CHK("upper byte", 8'hc3, rd)
    $display("dual map test done");
  endtask : t_dual
  // Lower half shared by both modes
  task automatic t_lower;
    acc(4'h8, 10'h045, 8'h5a);
    acc(4'h4, 10'h045, 8'h00);
    `CHK("lower ind", 8'h5a, rd)
    acc(4'hc, 10'h07f, 8'ha5);
    acc(4'h0, 10'h07f, 8'h00);
    `CHK("lower dir", 8'ha5, rd)
    $display("lower test done");
  endtask : t_lower
  // Banks, bit area and bit addressing
  task automatic t_bits;
    acc(4'h8, 10'h01a, 8'h11);
    `CHK("bank hit", 1'b1, hit_bank_ff)
    `CHK("bank num", 2'h3, bank_num_ff)
    `CHK("area miss", 1'b0, hit_bitarea_ff)
    acc(4'h8, 10'h021, 8'h00);
    `CHK("bank miss", 1'b0, hit_bank_ff)
    acc(4'ha, 10'h00b, 8'h01);
    acc(4'h0, 10'h021, 8'h00);
    `CHK("bit byte", 8'h08, rd)
    `CHK("bit area", 1'b1, hit_bitarea_ff)
    acc(4'h2, 10'h00b, 8'h00);
    `CHK("bit read", 8'h01, rd)
    acc(4'h8, 10'h098, 8'h08);
    acc(4'ha, 10'h09d, 8'h01);
    `CHK("sfs bit en", 1'b1, sfs_bit_en_ff)
    `CHK("sfs bit sel", 3'h5, sfs_bit_sel_ff)
    `CHK("sfs bit addr", 8'h98, sfs_addr_ff)
    acc(4'h2, 10'h09b, 8'h00);
    `CHK("sfs bit read", 8'h01, rd)
    acc(4'h0, 10'h098, 8'h00);
    `CHK("sfs bit merged", 8'h28, rd)
    `CHK("sfs byte mode", 1'b0, sfs_bit_en_ff)
    $display("bit test done");
  endtask : t_bits
  // Extra RAM at both ends, apart from direct byte zero
  task automatic t_ext;
    acc(4'h9, 10'h000, 8'h77);
    acc(4'h9, 10'h1ff, 8'h66);
    acc(4'h8, 10'h000, 8'h00);
    acc(4'h1, 10'h000, 8'h00);
    `CHK("ext low", 8'h77, rd)
    acc(4'h1, 10'h1ff, 8'h00);
    `CHK("ext high", 8'h66, rd)
    acc(4'h1, 10'h200, 8'h00);
    `CHK("ext beyond", 8'h66, rd)
    $display("extra RAM test done");
  endtask : t_ext
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    t_dual();
    t_lower();
    t_bits();
    t_ext();
    final_report();
  end
endmodule : internal_data_memory_decoder_tb
`default_nettype wire
